// ==== src/i2c_slave_pkg.sv ====
package i2c_slave_pkg;

	// counter width for the serial clock pulses of one byte plus acknowledge
	localparam int unsigned CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	// data pulses per byte, and the pulse that carries the acknowledge
	localparam logic [CNT_W-1:0] DATA_BITS = 4'h8;
	localparam logic [CNT_W-1:0] ACK_PULSE = 4'h9;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned ADDR_W = 7;
	// direction bit position in the address byte
	localparam int unsigned RW_POS = 0;
	localparam int unsigned MSB_POS = BYTE_W - 1;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 7'h00;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_RX,
		ST_TX,
		ST_SKIP
	} state_t;

endpackage

// ==== src/i2c_bus_sync.sv ====
`timescale 1ns/10ps
module i2c_bus_sync (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic rstn,
	// raw bus levels
	input  wire logic sclIn,
	input  wire logic sdaIn,
	// sampled levels and events
	output logic      sclLevel,
	output logic      sdaLevel,
	output logic      sclRise,
	output logic      sclFall,
	output logic      startSeen,
	output logic      stopSeen
);
	logic [1:0] sclMeta_reg;
	logic [1:0] sdaMeta_reg;
	logic       sclLast_reg;
	logic       sdaLast_reg;

	// two stages before anything looks at the pins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sclMeta_reg <= 2'h3;
			sdaMeta_reg <= 2'h3;
		end else begin
			sclMeta_reg <= {sclMeta_reg[0], sclIn};
			sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sclLast_reg <= 1'b1;
			sdaLast_reg <= 1'b1;
		end else begin
			sclLast_reg <= sclMeta_reg[1];
			sdaLast_reg <= sdaMeta_reg[1];
		end
	end

	assign sclLevel  = sclMeta_reg[1];
	assign sdaLevel  = sdaMeta_reg[1];
	assign sclRise   = sclMeta_reg[1] && !sclLast_reg;
	assign sclFall   = !sclMeta_reg[1] && sclLast_reg;
	// data moving while the clock is high marks start and stop
	assign startSeen = sclMeta_reg[1] && sclLast_reg && sdaLast_reg && !sdaMeta_reg[1];
	assign stopSeen  = sclMeta_reg[1] && sclLast_reg && !sdaLast_reg && sdaMeta_reg[1];

endmodule // i2c_bus_sync

// ==== src/i2c_slave_transmit_and_stretch.sv ====
`timescale 1ns/10ps
// Operation
// - matched address with direction one sets the read/write flag
// - management mode forces the received direction bit to zero
// - management mode still interrupts on a direction-one match; software abandons it
// - writing the transmit buffer sets the transmit-full flag
// - outgoing data bits change on serial clock falling edges; the first also on a transmit buffer write
// - transmit-full clears after all eight bits are shifted out
// - master acknowledge sampled at rising edge of the ninth clock
// - low acknowledge continues, interrupts, and shows in the ack status
// - slave interrupt raised at falling edge of the ninth clock
// - high acknowledge ends transfer, interrupts, idles until next start
// - stretch enabled and receive full at ninth clock: clear release, hold clock
// - software setting the release bit frees the serial clock line
// - transmit mode clears release and holds clock after read match or ack
// - reading the receive buffer clears the receive-full flag
module i2c_slave_transmit_and_stretch
	import i2c_slave_pkg::*;
(
	// clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rstn,
	// serial clock pin
	input  wire logic              sclIn,
	output logic                   sclOut,
	output logic                   sclOeN,
	// serial data pin
	input  wire logic              sdaIn,
	output logic                   sdaOut,
	output logic                   sdaOeN,
	// configuration
	input  wire logic [ADDR_W-1:0] ownAddress,
	input  wire logic              rxStretchEnable,
	input  wire logic              mgmtModeEnable,
	// software side of the buffers
	input  wire logic              txWrite,
	input  wire logic [BYTE_W-1:0] txData,
	input  wire logic              rxRead,
	output logic      [BYTE_W-1:0] rxData,
	// software control
	input  wire logic              clockReleaseSet,
	input  wire logic              clockReleaseClear,
	input  wire logic              slaveIrqClear,
	// status
	output logic                   txBufferFull,
	output logic                   rxBufferFull,
	output logic                   readWriteFlag,
	output logic                   ackStatusBit,
	output logic                   clockReleaseBit,
	output logic                   slaveInterruptFlag
);
	logic              sclLevel;
	logic              sdaLevel;
	logic              sclRise;
	logic              sclFall;
	logic              startSeen;
	logic              stopSeen;
	state_t            state_reg;
	logic [CNT_W-1:0]  bitCnt_reg;
	logic [BYTE_W-1:0] rxShift_reg;
	logic [BYTE_W-1:0] txShift_reg;
	logic              sdaLow_reg;
	logic              sclHold_reg;
	logic              addrMatch_reg;
	logic              ackPhase;
	logic              byteEnd;
	logic              rawRw;
	logic              rxLoad;
	logic              relClearHw;

	i2c_bus_sync busSync (
		.sys_clk  (sys_clk),
		.rstn     (rstn),
		.sclIn    (sclIn),
		.sdaIn    (sdaIn),
		.sclLevel (sclLevel),
		.sdaLevel (sdaLevel),
		.sclRise  (sclRise),
		.sclFall  (sclFall),
		.startSeen(startSeen),
		.stopSeen (stopSeen)
	);

	// falling edge after eighth pulse opens the acknowledge slot
	assign ackPhase = sclFall && (bitCnt_reg == DATA_BITS);
	assign byteEnd  = sclFall && (bitCnt_reg == ACK_PULSE);
	assign rawRw    = rxShift_reg[RW_POS];
	assign rxLoad   = ackPhase && (state_reg == ST_RX) && !rxBufferFull;
	assign relClearHw = byteEnd && (((state_reg == ST_RX) && rxStretchEnable && rxBufferFull)
		|| ((state_reg == ST_ADDR) && addrMatch_reg && rawRw && !mgmtModeEnable)
		|| ((state_reg == ST_TX) && !ackStatusBit));

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_reg  <= ST_IDLE;
			bitCnt_reg <= CNT_ZERO;
		end else if (startSeen) begin
			state_reg  <= ST_ADDR;
			bitCnt_reg <= CNT_ZERO;
		end else if (stopSeen) begin
			state_reg  <= ST_IDLE;
			bitCnt_reg <= CNT_ZERO;
		end else begin
			if (sclRise && bitCnt_reg != ACK_PULSE)
				bitCnt_reg <= bitCnt_reg + CNT_ONE;
			if (byteEnd) begin
				bitCnt_reg <= CNT_ZERO;
				case (state_reg)
					ST_ADDR: begin
						if (!addrMatch_reg)
							state_reg <= ST_SKIP;
						else if (rawRw && !mgmtModeEnable)
							state_reg <= ST_TX;
						else
							state_reg <= ST_RX;
					end
					ST_TX: state_reg <= ackStatusBit ? ST_IDLE : ST_TX;
					ST_RX: state_reg <= ST_RX;
					default: state_reg <= state_reg;
				endcase
			end
		end
	end

	// incoming bits, sampled while the clock is high
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			rxShift_reg <= BYTE_ZERO;
		else if (sclRise && bitCnt_reg < DATA_BITS)
			rxShift_reg <= {rxShift_reg[MSB_POS-1:0], sdaLevel};
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			addrMatch_reg <= 1'b0;
		else if (ackPhase && state_reg == ST_ADDR)
			addrMatch_reg <= (rxShift_reg[MSB_POS:1] == ownAddress);
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rxData       <= BYTE_ZERO;
			rxBufferFull <= 1'b0;
		end else if (rxLoad) begin
			rxData       <= rxShift_reg;
			rxBufferFull <= 1'b1;
		end else if (rxRead) begin
			rxBufferFull <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			readWriteFlag <= 1'b0;
		else if (byteEnd && state_reg == ST_ADDR && addrMatch_reg)
			readWriteFlag <= rawRw && !mgmtModeEnable;
	end

	// the shift register doubles as the transmit buffer to save a byte of flops
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			txShift_reg  <= BYTE_ZERO;
			txBufferFull <= 1'b0;
		end else if (txWrite) begin
			txShift_reg  <= txData;
			txBufferFull <= 1'b1;
		end else if (state_reg == ST_TX && sclFall) begin
			if (bitCnt_reg >= CNT_ONE && bitCnt_reg < DATA_BITS)
				txShift_reg <= {txShift_reg[MSB_POS-1:0], 1'b0};
			if (bitCnt_reg == DATA_BITS)
				txBufferFull <= 1'b0;
		end
	end

	// data line drive: ack slot when receiving, data bits when sending
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sdaLow_reg <= 1'b0;
		end else if (startSeen || stopSeen) begin
			sdaLow_reg <= 1'b0;
		end else if (state_reg == ST_TX) begin
			if (txWrite && bitCnt_reg == CNT_ZERO)
				sdaLow_reg <= !txData[MSB_POS];
			else if (sclFall && bitCnt_reg >= CNT_ONE && bitCnt_reg < DATA_BITS)
				sdaLow_reg <= !txShift_reg[MSB_POS-1];
			else if (sclFall)
				sdaLow_reg <= 1'b0;
		end else if (ackPhase) begin
			sdaLow_reg <= (state_reg == ST_ADDR) ? (rxShift_reg[MSB_POS:1] == ownAddress)
				: (state_reg == ST_RX) && !rxBufferFull;
		end else if (byteEnd) begin
			// first data bit of a read goes out as the address slot ends if the transmit buffer is already full
			sdaLow_reg <= (state_reg == ST_ADDR) && addrMatch_reg && rawRw && !mgmtModeEnable
				&& txBufferFull && !txShift_reg[MSB_POS];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			ackStatusBit <= 1'b0;
		else if (state_reg == ST_TX && sclRise && bitCnt_reg == DATA_BITS)
			ackStatusBit <= sdaLevel;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			slaveInterruptFlag <= 1'b0;
		else if (byteEnd && (state_reg == ST_TX || state_reg == ST_RX
			|| (state_reg == ST_ADDR && addrMatch_reg)))
			slaveInterruptFlag <= 1'b1;
		else if (slaveIrqClear)
			slaveInterruptFlag <= 1'b0;
	end

	// hardware clear wins so a stretch is never missed
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			clockReleaseBit <= 1'b1;
		else if (relClearHw || clockReleaseClear)
			clockReleaseBit <= 1'b0;
		else if (clockReleaseSet)
			clockReleaseBit <= 1'b1;
	end

	// a hold starts only once the bus clock is already low, so no pulse is cut short
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			sclHold_reg <= 1'b0;
		else
			sclHold_reg <= !clockReleaseBit && (sclHold_reg || !sclLevel);
	end

	assign sclOut = 1'b0;
	assign sdaOut = 1'b0;
	assign sclOeN = !sclHold_reg;
	assign sdaOeN = !sdaLow_reg;

	property p_txFullSet;
		@(posedge sys_clk) disable iff (!rstn) txWrite |=> txBufferFull;
	endproperty
	a_txFullSet: assert property (p_txFullSet) else $error("transmit full not set by write");

	property p_txFullClr;
		@(posedge sys_clk) disable iff (!rstn)
			(state_reg == ST_TX && ackPhase && !txWrite) |=> !txBufferFull;
	endproperty
	a_txFullClr: assert property (p_txFullClr) else $error("transmit full not cleared after byte");

	property p_rwSet;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_ADDR && addrMatch_reg && rawRw && !mgmtModeEnable)
			|=> readWriteFlag && state_reg == ST_TX;
	endproperty
	a_rwSet: assert property (p_rwSet) else $error("read match did not enter transmit");

	property p_mgmtNoTx;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_ADDR && addrMatch_reg && mgmtModeEnable && !startSeen && !stopSeen)
			|=> !readWriteFlag && state_reg != ST_TX;
	endproperty
	a_mgmtNoTx: assert property (p_mgmtNoTx) else $error("management mode entered transmit");

	property p_mgmtIrq;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_ADDR && addrMatch_reg && rawRw && mgmtModeEnable)
			|=> slaveInterruptFlag;
	endproperty
	a_mgmtIrq: assert property (p_mgmtIrq) else $error("no interrupt on management read");

	property p_ackSample;
		@(posedge sys_clk) disable iff (!rstn)
			(state_reg == ST_TX && sclRise && bitCnt_reg == DATA_BITS) |=> ackStatusBit == $past(sdaLevel);
	endproperty
	a_ackSample: assert property (p_ackSample) else $error("acknowledge not sampled");

	property p_txIrq;
		@(posedge sys_clk) disable iff (!rstn) (byteEnd && state_reg == ST_TX) |=> slaveInterruptFlag;
	endproperty
	a_txIrq: assert property (p_txIrq) else $error("no interrupt at ninth falling edge");

	property p_nackIdle;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_TX && ackStatusBit && !startSeen) |=> state_reg == ST_IDLE ##1 sdaOeN;
	endproperty
	a_nackIdle: assert property (p_nackIdle) else $error("nack did not end transfer");

	property p_rxStretch;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_RX && rxStretchEnable && rxBufferFull) |=> !clockReleaseBit ##2 !sclOeN;
	endproperty
	a_rxStretch: assert property (p_rxStretch) else $error("receive stretch missing");

	property p_txHold;
		@(posedge sys_clk) disable iff (!rstn)
			(byteEnd && state_reg == ST_TX && !ackStatusBit) |=> !clockReleaseBit;
	endproperty
	a_txHold: assert property (p_txHold) else $error("no hold after acknowledged byte");

	property p_release;
		@(posedge sys_clk) disable iff (!rstn)
			(clockReleaseSet && !relClearHw && !clockReleaseClear) |=> clockReleaseBit ##1 sclOeN;
	endproperty
	a_release: assert property (p_release) else $error("clock not released");

	property p_rxClear;
		@(posedge sys_clk) disable iff (!rstn) (rxRead && !rxLoad) |=> !rxBufferFull;
	endproperty
	a_rxClear: assert property (p_rxClear) else $error("receive full not cleared by read");

endmodule // i2c_slave_transmit_and_stretch

// ==== verification/i2c_master_model.sv ====
`timescale 1ns/10ps
module i2c_master_model (
	// clock
	input  wire logic sys_clk,
	// device pin enables
	input  wire logic sclOeN,
	input  wire logic sdaOeN,
	// wire levels, pulled up
	output logic      sclLine,
	output logic      sdaLine,
	// a clock hold outlasted its bound
	output logic      stuck
);
	// a quarter of the 160 ns serial clock period
	localparam int QUARTER = 8;
	localparam int HOLD_MAX = 4000;

	logic sclDrv = 1'b1;
	logic sdaDrv = 1'b1;

	initial stuck = 1'b0;

	// released lines float high through the pull-ups
	assign sclLine = sclDrv & sclOeN;
	assign sdaLine = sdaDrv & sdaOeN;

	task automatic quarter(input int n);
		repeat (n * QUARTER) @(negedge sys_clk);
	endtask

	task automatic clockHigh();
		int n;
		n = 0;
		sclDrv = 1'b1;
		while (sclLine !== 1'b1 && n < HOLD_MAX) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= HOLD_MAX) begin
			stuck = 1'b1;
		end
	endtask

	// data set up while the clock is low, sampled mid-high
	task automatic pulse(input logic b, output logic s);
		sdaDrv = b;
		quarter(2);
		clockHigh();
		quarter(1);
		s = sdaLine;
		quarter(1);
		sclDrv = 1'b0;
	endtask

	task automatic sendStart();
		sdaDrv = 1'b1;
		sclDrv = 1'b1;
		quarter(2);
		sdaDrv = 1'b0;
		quarter(2);
		sclDrv = 1'b0;
		quarter(1);
	endtask

	task automatic sendStop();
		sdaDrv = 1'b0;
		quarter(2);
		clockHigh();
		quarter(2);
		sdaDrv = 1'b1;
		quarter(2);
	endtask

	task automatic writeByte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(d[i], s);
		end
		pulse(1'b1, ack);
	endtask

	task automatic readByte(input logic ackBit, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			pulse(1'b1, d[i]);
		end
		pulse(ackBit, s);
		sdaDrv = 1'b1;
	endtask
endmodule // i2c_master_model

// ==== verification/i2c_slave_transmit_and_stretch_bench.sv ====
`timescale 1ns/10ps
module i2c_slave_transmit_and_stretch_bench
	import i2c_slave_pkg::*;
;
	logic              sys_clk           = 1'b0;
	logic              rstn              = 1'b0;
	logic [ADDR_W-1:0] ownAddress        = 7'h2a;
	logic              rxStretchEnable   = 1'b0;
	logic              mgmtModeEnable    = 1'b0;
	logic              txWrite           = 1'b0;
	logic [BYTE_W-1:0] txData            = 8'h00;
	logic              rxRead            = 1'b0;
	logic              clockReleaseSet   = 1'b0;
	logic              clockReleaseClear = 1'b0;
	logic              slaveIrqClear     = 1'b0;
	logic [BYTE_W-1:0] rxData;
	logic              sclOeN;
	logic              sdaOeN;
	logic              sclOut;
	logic              sdaOut;
	logic              sclLine;
	logic              sdaLine;
	logic              stuck;
	logic              txBufferFull;
	logic              rxBufferFull;
	logic              readWriteFlag;
	logic              ackStatusBit;
	logic              clockReleaseBit;
	logic              slaveInterruptFlag;
	int                err_total         = 0;
	int                n_checks          = 0;

	always #2.5 sys_clk = ~sys_clk;

	i2c_slave_transmit_and_stretch dut (
		.sys_clk(sys_clk), .rstn(rstn), .sclIn(sclLine), .sclOut(sclOut), .sclOeN(sclOeN),
		.sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .ownAddress(ownAddress),
		.rxStretchEnable(rxStretchEnable), .mgmtModeEnable(mgmtModeEnable),
		.txWrite(txWrite), .txData(txData), .rxRead(rxRead), .rxData(rxData),
		.clockReleaseSet(clockReleaseSet), .clockReleaseClear(clockReleaseClear),
		.slaveIrqClear(slaveIrqClear), .txBufferFull(txBufferFull), .rxBufferFull(rxBufferFull),
		.readWriteFlag(readWriteFlag), .ackStatusBit(ackStatusBit),
		.clockReleaseBit(clockReleaseBit), .slaveInterruptFlag(slaveInterruptFlag)
	);

	i2c_master_model master (
		.sys_clk(sys_clk), .sclOeN(sclOeN), .sdaOeN(sdaOeN),
		.sclLine(sclLine), .sdaLine(sdaLine), .stuck(stuck)
	);

	task automatic end_of_test();
		if (err_total == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic waitCycles(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic strobe(ref logic s);
		@(negedge sys_clk);
		s = 1'b1;
		@(negedge sys_clk);
		s = 1'b0;
	endtask

	task automatic writeStretch();
		logic a;
		rxStretchEnable = 1'b1;
		master.sendStart();
		master.writeByte(8'h54, a);
		check("address ack", a, 1'b0);
		strobe(slaveIrqClear);
		master.writeByte(8'hc3, a);
		waitCycles(4);
		check("rx data", rxData, 8'hc3);
		check("rx full", rxBufferFull, 1'b1);
		check("rx hold", {clockReleaseBit, sclOeN}, 2'b00);
		strobe(rxRead);
		waitCycles(2);
		check("rx full", rxBufferFull, 1'b0);
		strobe(clockReleaseSet);
		waitCycles(3);
		check("release", {clockReleaseBit, sclOeN}, 2'b11);
		// software suspend only bites once the clock is seen low
		strobe(clockReleaseClear);
		waitCycles(4);
		check("suspend", sclOeN, 1'b0);
		strobe(clockReleaseSet);
		strobe(slaveIrqClear);
		master.sendStop();
		rxStretchEnable = 1'b0;
	endtask

	task automatic readTransmit();
		logic a;
		logic [7:0] d;
		master.sendStart();
		master.writeByte(8'h55, a);
		waitCycles(4);
		check("rw flag", readWriteFlag, 1'b1);
		check("address hold", {slaveInterruptFlag, clockReleaseBit, sclOeN}, 3'b100);
		strobe(slaveIrqClear);
		txData = 8'ha5;
		strobe(txWrite);
		waitCycles(1);
		check("tx full", txBufferFull, 1'b1);
		// set-up margin before the clock is let go
		waitCycles(8);
		strobe(clockReleaseSet);
		master.readByte(1'b0, d);
		waitCycles(4);
		check("tx byte", d, 8'ha5);
		check("tx full", txBufferFull, 1'b0);
		check("ack status", ackStatusBit, 1'b0);
		check("irq", slaveInterruptFlag, 1'b1);
		check("ack hold", {clockReleaseBit, sclOeN}, 2'b00);
		strobe(slaveIrqClear);
		txData = 8'h3c;
		strobe(txWrite);
		waitCycles(8);
		strobe(clockReleaseSet);
		master.readByte(1'b1, d);
		waitCycles(4);
		check("tx byte", d, 8'h3c);
		check("ack status", ackStatusBit, 1'b1);
		check("nack end", {slaveInterruptFlag, clockReleaseBit, sclOeN}, 3'b111);
		strobe(slaveIrqClear);
		master.sendStop();
	endtask

	task automatic mgmtMode();
		logic a;
		mgmtModeEnable = 1'b1;
		master.sendStart();
		master.writeByte(8'h55, a);
		waitCycles(4);
		check("rw flag", readWriteFlag, 1'b0);
		check("irq", slaveInterruptFlag, 1'b1);
		strobe(slaveIrqClear);
		master.sendStop();
		master.sendStart();
		master.writeByte(8'h3e, a);
		check("foreign ack", a, 1'b1);
		master.sendStop();
		mgmtModeEnable = 1'b0;
	endtask

	always @(posedge stuck) begin
		err_total++;
		end_of_test();
	end

	initial begin
		waitCycles(8);
		rstn = 1'b1;
		waitCycles(4);
		check("reset state", {txBufferFull, rxBufferFull, readWriteFlag, ackStatusBit,
			clockReleaseBit, slaveInterruptFlag, sclOeN, sdaOeN}, 8'h0b);
		check("reset rx data", rxData, 8'h00);
		// open-drain pins only ever pull low
		check("pin drive values", {sclOut, sdaOut}, 2'h0);
		writeStretch();
		readTransmit();
		mgmtMode();
		end_of_test();
	end
endmodule // i2c_slave_transmit_and_stretch_bench
